// ### hw/timer_compare_trigger_reset.sv
// Compare-triggered 16-bit timer with conversion start and period reset.
`default_nettype none
module timer_compare_trigger_reset
  import tmr_trig_pkg::*;
#(
  parameter int unsigned UNITS = NUM_UNITS
) (
  // Clock and reset
  input  wire logic                 ref_clk_i,
  input  wire logic                 sys_rst_i,
  // Timer control
  input  wire logic                 timer_on_i,
  input  wire logic [1:0]           clk_src_i,
  input  wire logic                 async_mode_i,
  input  wire logic                 ext_clk_i,
  // Software access to the count bytes
  input  wire logic                 wr_low_i,
  input  wire logic                 wr_high_i,
  input  wire logic [7:0]           wr_data_i,
  input  wire logic                 rollover_clr_i,
  // Compare units
  input  wire logic [UNITS-1:0]     cmp_en_i,
  input  wire logic [UNITS-1:0]     trig_mode_i,
  input  wire logic [UNITS-1:0]     cmp_irq_en_i,
  input  wire logic [UNITS*16-1:0]  compare_value_i,
  input  wire logic [UNITS-1:0]     cmp_flag_clr_i,
  // Outputs
  output logic [7:0]                timer_count_low_o,
  output logic [7:0]                timer_count_high_o,
  output logic                      timer_rollover_flag_o,
  output logic [UNITS-1:0]          cmp_flag_o,
  output logic                      conv_start_o
);

  // ---------------------------------------------------------------
  // Tick generation
  // ---------------------------------------------------------------
  logic [15:0]      count_r;
  logic [1:0]       div_r;
  logic [2:0]       ext_sync_r;
  logic             ext_level_r;
  logic             tick;
  logic             ext_edge;
  logic             sync_ok;

  // The divider runs freely from reset, so the first instruction tick after the timer is
  // switched on comes one to four cycles later.
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      div_r <= DIV_RST;
    end else begin
      div_r <= (div_r == 2'(INSTR_DIV_CYCLES - 1)) ? DIV_RST : div_r + 2'h1;
    end
  end

  // ---------------------------------------------------------------
  // External count pin and tick select
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ext_sync_r <= 3'h0;
    end else begin
      ext_sync_r <= {ext_sync_r[1:0], ext_clk_i};
    end
  end

  // The pin level is taken over only once the second and third stages agree, so a
  // sample caught while the pin moves never counts as an edge on its own.
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ext_level_r <= 1'b0;
    end else if (ext_sync_r[1] == ext_sync_r[2]) begin
      ext_level_r <= ext_sync_r[2];
    end
  end

  // Rising edge once the second and third stages agree on a new high level.
  assign ext_edge = ext_sync_r[1] & ext_sync_r[2] & ~ext_level_r;

  always_comb begin
    case (clk_src_t'(clk_src_i))
      CLK_INSTR: tick = timer_on_i & (div_r == 2'(INSTR_DIV_CYCLES - 1));
      CLK_SYS:   tick = timer_on_i;
      CLK_EXT:   tick = timer_on_i & ext_edge;
      default:   tick = 1'b0;
    endcase
  end

  // Asynchronous counting gives no delivery guarantee for the trigger.
  assign sync_ok = ~async_mode_i;

  // ---------------------------------------------------------------
  // Compare units
  // ---------------------------------------------------------------
  logic [UNITS-1:0] match;
  logic [UNITS-1:0] trig;
  logic             any_trig;
  logic [UNITS-1:0] period_hit;

  // A match is acted on only in a tick cycle: with a slow source the count rests on the
  // compare value for several clocks and must still trigger just once.
  genvar g;
  generate
    for (g = 0; g < UNITS; g++) begin : g_unit
      assign match[g]      = cmp_en_i[g] & (compare_value_i[g*TIMER_W +: TIMER_W] == count_r);
      assign period_hit[g] = cmp_en_i[g] & trig_mode_i[g] & (compare_value_i[g*TIMER_W +: TIMER_W] == count_r);
      assign trig[g]  = match[g] & trig_mode_i[g] & tick & sync_ok;

      // Set wins over a clear in the same cycle.
      always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
          cmp_flag_o[g] <= 1'b0;
        end else if (match[g] & tick & cmp_irq_en_i[g]) begin
          cmp_flag_o[g] <= 1'b1;
        end else if (cmp_flag_clr_i[g]) begin
          cmp_flag_o[g] <= 1'b0;
        end
      end
    end
  endgenerate

  assign any_trig = |trig;

  // ---------------------------------------------------------------
  // Counter
  // ---------------------------------------------------------------
  logic sw_wr;
  logic wrap;

  assign sw_wr = wr_low_i | wr_high_i;
  // A trigger takes the count back to zero itself, which must never pass for a rollover.
  assign wrap  = tick & (count_r == COUNT_MAX) & ~any_trig;

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      count_r <= COUNT_RST;
    end else if (sw_wr) begin
      // A write outranks a trigger clear in the same cycle.
      if (wr_low_i) begin
        count_r[7:0] <= wr_data_i;
      end
      if (wr_high_i) begin
        count_r[15:8] <= wr_data_i;
      end
    end else if (any_trig) begin
      count_r <= COUNT_RST;
    end else if (tick) begin
      count_r <= count_r + 16'h0001;
    end
  end

  assign timer_count_low_o  = count_r[7:0];
  assign timer_count_high_o = count_r[15:8];

  // Set wins over a clear in the same cycle, so a rollover that meets the clear is not lost.
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      timer_rollover_flag_o <= 1'b0;
    end else if (wrap & ~sw_wr) begin
      timer_rollover_flag_o <= 1'b1;
    end else if (rollover_clr_i) begin
      timer_rollover_flag_o <= 1'b0;
    end
  end

  // A start follows every trigger, also one whose clear lost to a software write, since the
  // conversion request does not depend on the count.
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      conv_start_o <= 1'b0;
    end else begin
      conv_start_o <= any_trig;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  sequence s_trig_clear;
    any_trig & ~sw_wr ##1 (count_r == COUNT_RST);
  endsequence

  // A trigger-mode unit sitting on its compare value in a tick cycle ends the period.
  sequence s_period_hit;
    tick & ~async_mode_i & ~sw_wr & (|period_hit);
  endsequence

  sequence s_wrap;
    wrap & ~sw_wr;
  endsequence

  a_trig_starts_conv: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    any_trig |=> conv_start_o) else $error("conversion start missing after trigger");
  a_trig_clears_count: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    any_trig & ~sw_wr |-> s_trig_clear) else $error("count not cleared by trigger");
  a_trig_no_rollover: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    any_trig & ~timer_rollover_flag_o |=> ~timer_rollover_flag_o) else $error("trigger set rollover flag");
  a_cmp_flag_set: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    |(match & cmp_irq_en_i) & tick |=> |cmp_flag_o) else $error("compare flag not raised");
  a_period_restart: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    s_period_hit |=> count_r == COUNT_RST) else $error("period restart failed");
  a_async_no_trig: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    async_mode_i |-> ~any_trig) else $error("trigger while asynchronous");
  a_write_wins: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    any_trig & wr_low_i & ~wr_high_i |=> timer_count_low_o == $past(wr_data_i)) else $error("write lost to trigger");
  a_wrap_sets_flag: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    s_wrap |=> timer_rollover_flag_o && count_r == COUNT_RST) else $error("wrap not flagged");
  a_step_after_trig: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    any_trig & ~sw_wr ##1 (tick & ~any_trig & ~sw_wr) |=> count_r == 16'h0001) else $error("period off by one");

  // Supporting checks on the flag, the count, the conversion start and the external edge.
  a_flag_set_wins: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    s_wrap ##0 rollover_clr_i |=> timer_rollover_flag_o) else $error("rollover lost to clear");
  a_flag_only_wrap: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    ~timer_rollover_flag_o & ~wrap |=> ~timer_rollover_flag_o) else $error("rollover flag without wrap");
  a_count_holds: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    ~tick & ~sw_wr |=> $stable(count_r)) else $error("count moved without tick");
  a_start_needs_trig: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    ~any_trig |=> ~conv_start_o) else $error("start without trigger");
  a_ext_single_tick: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    ext_edge |=> ~ext_edge) else $error("external edge held");

endmodule : timer_compare_trigger_reset
`default_nettype wire

// ### pkg/tmr_trig_pkg.sv
// Constants and types for the compare-triggered 16-bit timer.
// Notes on behaviour
// - A conversion trigger from any compare unit in trigger mode also issues a conversion start to the converter.
// - Each conversion trigger without a software count write in the same cycle clears both bytes of the 16-bit timer count to zero.
// - A clear caused by the conversion trigger never sets the timer rollover flag.
// - A compare match that makes a conversion trigger still raises the compare unit's own interrupt flag when enabled.
// - In trigger mode the compare value pair acts as the timer period, restarting the count from zero on reaching it.
// - When the timer counts asynchronously a conversion trigger may be missed and is not guaranteed.
// - A software write to either count byte in the same cycle as a trigger clear is stored and the clear is dropped.
// - The count increments to its maximum, wraps to zero and sets the rollover flag.
// - In compare mode the unit raises its event when the compare pair equals the timer count.
`default_nettype none
package tmr_trig_pkg;
  localparam int unsigned TIMER_W          = 16;
  localparam int unsigned NUM_UNITS        = 2;
  localparam logic [15:0] COUNT_RST        = 16'h0000;
  localparam logic [15:0] COUNT_MAX        = 16'hFFFF;
  localparam int unsigned INSTR_DIV_CYCLES = 4;
  localparam logic [1:0]  DIV_RST          = 2'h0;

  typedef enum logic [1:0] {
    CLK_INSTR = 2'b00,
    CLK_SYS   = 2'b01,
    CLK_EXT   = 2'b11
  } clk_src_t;
endpackage : tmr_trig_pkg
`default_nettype wire

// ### verification/conv_start_model.sv
// Converter start model that counts the start requests it receives from the timer.
`default_nettype none
module conv_start_model (
  // Clock and reset
  input  wire logic       ref_clk_i,
  input  wire logic       sys_rst_i,
  // Start request
  input  wire logic       conv_start_i,
  // Observed number of starts
  output var  logic [7:0] starts_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // A start is a single-cycle pulse, so every high cycle is one conversion.
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) starts_o <= 8'h00;
    else if (conv_start_i) starts_o <= starts_o + 8'h01;
  end
endmodule : conv_start_model
`default_nettype wire

// ### verification/tb.sv
// Self-checking testbench for the compare-triggered timer.
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        ref_clk_i = 1'b0, sys_rst_i = 1'b1, timer_on_i = 1'b0, async_mode_i = 1'b0, ext_clk_i = 1'b0;
  logic        wr_low_i = 1'b0, wr_high_i = 1'b0, rollover_clr_i = 1'b0, timer_rollover_flag_o, conv_start_o;
  logic [1:0]  clk_src_i = 2'h1, cmp_en_i = 2'h0, trig_mode_i = 2'h0, cmp_irq_en_i = 2'h0, cmp_flag_clr_i = 2'h0;
  logic [1:0]  cmp_flag_o;
  logic [7:0]  wr_data_i = 8'h00, timer_count_low_o, timer_count_high_o, starts;
  logic [31:0] compare_value_i = 32'h0000_0000;
  int          error_cnt = 0, checks_done = 0;
  wire  [15:0] cnt = {timer_count_high_o, timer_count_low_o};
  timer_compare_trigger_reset uut (.ref_clk_i, .sys_rst_i, .timer_on_i, .clk_src_i, .async_mode_i, .ext_clk_i,
    .wr_low_i, .wr_high_i, .wr_data_i, .rollover_clr_i, .cmp_en_i, .trig_mode_i, .cmp_irq_en_i, .compare_value_i,
    .cmp_flag_clr_i, .timer_count_low_o, .timer_count_high_o, .timer_rollover_flag_o, .cmp_flag_o, .conv_start_o);
  conv_start_model adc (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .conv_start_i(conv_start_o), .starts_o(starts));
  always #10 ref_clk_i = ~ref_clk_i;
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic results;
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : results
  task automatic wr(input logic lo, input logic hi, input logic [7:0] d);
    @(negedge ref_clk_i);
    wr_low_i = lo; wr_high_i = hi; wr_data_i = d;
    @(negedge ref_clk_i);
    wr_low_i = 1'b0; wr_high_i = 1'b0;
  endtask : wr
  // Unit 1 alone is set up, so a trigger from a unit other than unit 0 is exercised.
  task automatic test_period;
    cmp_en_i = 2'h2; trig_mode_i = 2'h2; cmp_irq_en_i = 2'h2; compare_value_i = 32'h0002_0000;
    @(negedge ref_clk_i) timer_on_i = 1'b1;
    @(negedge ref_clk_i) check(cnt, 16'h0001);
    @(negedge ref_clk_i) check(cnt, 16'h0002);
    @(negedge ref_clk_i) check(cnt, 16'h0000);
    check(conv_start_o, 16'h0001);
    check(cmp_flag_o, 16'h0002);
    check(timer_rollover_flag_o, 16'h0000);
    @(negedge ref_clk_i) check(cnt, 16'h0001);
    check(conv_start_o, 16'h0000);
    $display("test_period done");
  endtask : test_period
  // The write lands in the very cycle the count matches, so it is kept while the start still goes out.
  task automatic test_write_wins;
    @(negedge ref_clk_i) check(cnt, 16'h0002);
    wr_low_i = 1'b1; wr_data_i = 8'h55;
    @(negedge ref_clk_i) wr_low_i = 1'b0;
    timer_on_i = 1'b0;
    check(cnt, 16'h0055);
    check(conv_start_o, 16'h0001);
    $display("test_write_wins done");
  endtask : test_write_wins
  task automatic test_rollover;
    cmp_en_i = 2'h0; trig_mode_i = 2'h0; cmp_flag_clr_i = 2'h3;
    wr(1'b1, 1'b1, 8'hFF);
    cmp_flag_clr_i = 2'h0;
    check(cnt, 16'hFFFF);
    check(cmp_flag_o, 16'h0000);
    // The clear is held through the wrap, where the set must win.
    timer_on_i = 1'b1;
    rollover_clr_i = 1'b1;
    @(negedge ref_clk_i) timer_on_i = 1'b0;
    check(cnt, 16'h0000);
    check(timer_rollover_flag_o, 16'h0001);
    rollover_clr_i = 1'b1;
    @(negedge ref_clk_i) rollover_clr_i = 1'b0;
    check(timer_rollover_flag_o, 16'h0000);
    $display("test_rollover done");
  endtask : test_rollover
  // Asynchronous counting drops triggers, so no further start may appear.
  task automatic test_async;
    logic [7:0] base;
    wr(1'b1, 1'b1, 8'h00);
    base = starts;
    cmp_en_i = 2'h1; trig_mode_i = 2'h1; compare_value_i = 32'h0000_0001; async_mode_i = 1'b1;
    timer_on_i = 1'b1;
    repeat (5) @(negedge ref_clk_i);
    timer_on_i = 1'b0;
    check(starts, {8'h00, base});
    $display("test_async done");
  endtask : test_async
  // The instruction clock ticks every four cycles, so a period of two ticks spans eight cycles.
  task automatic test_instr_clock;
    int k;
    wr(1'b1, 1'b1, 8'h00);
    async_mode_i = 1'b0;
    cmp_en_i = 2'h1;
    trig_mode_i = 2'h1;
    compare_value_i = 32'h0000_0001;
    clk_src_i = 2'h0;
    timer_on_i = 1'b1;
    for (k = 0; k < 8 && cnt != 16'h0001; k++) @(negedge ref_clk_i);
    check(cnt, 16'h0001);
    repeat (3) @(negedge ref_clk_i);
    check(cnt, 16'h0001);
    @(negedge ref_clk_i) check(cnt, 16'h0000);
    check(conv_start_o, 16'h0001);
    @(negedge ref_clk_i) check(conv_start_o, 16'h0000);
    repeat (3) @(negedge ref_clk_i);
    check(cnt, 16'h0001);
    timer_on_i = 1'b0;
    $display("test_instr_clock done");
  endtask : test_instr_clock
  // Each rising edge of the external pin advances the count once; the idle source never does.
  task automatic test_ext_clock;
    cmp_en_i = 2'h0;
    wr(1'b1, 1'b1, 8'h00);
    clk_src_i = 2'h3;
    timer_on_i = 1'b1;
    repeat (2) begin
      ext_clk_i = 1'b1;
      repeat (4) @(negedge ref_clk_i);
      ext_clk_i = 1'b0;
      repeat (4) @(negedge ref_clk_i);
    end
    check(cnt, 16'h0002);
    clk_src_i = 2'h2;
    ext_clk_i = 1'b1;
    repeat (4) @(negedge ref_clk_i);
    check(cnt, 16'h0002);
    timer_on_i = 1'b0;
    ext_clk_i = 1'b0;
    $display("test_ext_clock done");
  endtask : test_ext_clock
  initial begin
    repeat (2) @(posedge ref_clk_i);
    @(negedge ref_clk_i) sys_rst_i = 1'b0;
    test_period();
    test_write_wins();
    test_rollover();
    test_async();
    test_instr_clock();
    test_ext_clock();
    results();
  end
  // The tests take about 56 cycles; this limit leaves ample margin.
  initial begin
    #5000;
    error_cnt++;
    results();
  end
endmodule : tb
`default_nettype wire
